// ==== hdl/flash_pins_defs.vh ====
// Constants and offsets of the serial flash pin front end
`ifndef FLASH_PINS_DEFS_VH
`define FLASH_PINS_DEFS_VH

// Register byte offsets
`define OFS_STAT_LO 8'h00
`define OFS_STAT_HI 8'h04
`define OFS_CTRL 8'h08
`define OFS_TXD 8'h0C
`define OFS_RXD 8'h10
`define OFS_STATE 8'h14

// status_reg_low fields
`define SL_BP_LO 2
`define SL_BP_HI 4
`define SL_TB 5
`define SL_SEC 6
`define SL_LOCK0 7
// status_reg_high fields
`define SH_LOCK1 0
`define SH_QE 1
`define SH_CMP 6

// Control fields
`define CT_W_LO 0
`define CT_W_HI 1
`define CT_DIR 2
`define CT_BUSY 3

// Transfer widths
`define W_SINGLE 2'h0
`define W_DUAL 2'h1
`define W_QUAD 2'h2

// State register fields
`define ST_ACT 0
`define ST_ARMED 1
`define ST_PAUSE 2
`define ST_STBY 3
`define ST_LOCK 4
`define ST_RXV 5
`define ST_REJ 6
`define ST_ABORT 7
`define ST_QREF 8

// Reset values
`define RST_STAT_LO 8'h00
`define RST_STAT_HI 8'h00
`define RST_CTRL 4'h0
`define RST_TXD 8'hFF

`endif

// ==== hdl/sync_two.v ====
// Two-flop synchroniser, one stage pair per bit
module sync_two #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    // Clock and reset
    input wire mclk,
    input wire rst_b,
    // Data
    input wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] dout
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            reg meta_q;
            reg sync_q;
            always @(posedge mclk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    meta_q <= RST_VAL[i];
                    sync_q <= RST_VAL[i];
                end
                else
                begin
                    meta_q <= din[i];
                    sync_q <= meta_q;
                end
            end
            assign dout[i] = sync_q;
        end
    endgenerate
endmodule // sync_two

// ==== hdl/flash_pin_front.v ====
// Serial flash pin front end with an AHB-Lite register slave
//
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`include "flash_pins_defs.vh"

module flash_pin_front (
    // Clock and reset
    input wire mclk,
    input wire rst_b,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output wire [31:0] hrdata,
    // Serial link pins
    input wire chip_select_n,
    input wire serial_clock,
    // Data lines 0..3, enable low while driven
    input wire [3:0] data_line_in,
    output wire [3:0] data_line_out,
    output wire [3:0] data_line_oe_n,
    // Status towards the core
    output wire standby,
    output wire status_write_lock,
    output wire array_protect_lock,
    output wire [5:0] protect_region
);

    // Synchronised pins
    wire cs_s;
    wire sclk_s;
    wire [3:0] dl_s;

    // Select rests at 0 so a low held through reset is not taken as a fall
    sync_two #(
        .WIDTH(2),
        .RST_VAL(2'h0)
    ) u_sync_ctl (
        .mclk(mclk),
        .rst_b(rst_b),
        .din({chip_select_n, serial_clock}),
        .dout({cs_s, sclk_s})
    );

    // Lines rest high, as the pad pull-ups would make them
    sync_two #(
        .WIDTH(4),
        .RST_VAL(4'hF)
    ) u_sync_dl (
        .mclk(mclk),
        .rst_b(rst_b),
        .din(data_line_in),
        .dout(dl_s)
    );

    // Registers
    reg cs_p_q;
    reg sclk_p_q;
    reg armed_q;
    reg paused_q;
    reg [7:0] stat_lo_q;
    reg [7:0] stat_hi_q;
    reg [3:0] ctrl_q;
    reg [7:0] txd_q;
    reg [7:0] rxd_q;
    reg rx_valid_q;
    reg sr_reject_q;
    reg abort_q;
    reg quad_ref_q;
    reg [7:0] rx_sh_q;
    reg [3:0] rx_cnt_q;
    reg [7:0] tx_sh_q;
    reg [3:0] tx_cnt_q;
    reg skip_q;
    reg [3:0] dl_out_q;
    reg standby_q;
    reg lock_q;
    reg [5:0] region_q;
    reg a_wr_q;
    reg [7:0] a_addr_q;
    reg [31:0] hrdata_q;

    // Edges and derived levels
    wire cs_fall = cs_p_q & ~cs_s;
    wire cs_rise = ~cs_p_q & cs_s;
    wire sclk_rise = sclk_s & ~sclk_p_q;
    wire sclk_fall = ~sclk_s & sclk_p_q;
    wire active = armed_q & ~cs_s;
    wire qe = stat_hi_q[`SH_QE];
    wire [1:0] w_req = ctrl_q[`CT_W_HI:`CT_W_LO];
    wire dir_out = ctrl_q[`CT_DIR];
    wire busy = ctrl_q[`CT_BUSY];

    // Quad without the enable bit falls back to single-bit transfers
    reg [1:0] width;
    always @*
    begin
        if (w_req == `W_QUAD && qe)
            width = `W_QUAD;
        else if (w_req == `W_DUAL)
            width = `W_DUAL;
        else
            width = `W_SINGLE;
    end

    wire quad = (width == `W_QUAD);
    wire hold_n = dl_s[3];
    wire wp_n = dl_s[2];

    // Protect pin acts only outside quad enable
    wire hw_lock = ~qe & ~wp_n & ~stat_hi_q[`SH_LOCK1]
                   & stat_lo_q[`SL_LOCK0];

    // Bits moved per serial clock edge
    reg [3:0] step;
    always @*
    begin
        case (width)
            `W_DUAL: step = 4'h2;
            `W_QUAD: step = 4'h4;
            default: step = 4'h1;
        endcase
    end

    // Serial traffic moves only while selected and not paused
    wire link_on = active & ~paused_q;
    wire rx_edge = link_on & ~dir_out & sclk_rise;
    wire tx_edge = link_on & dir_out & sclk_fall;
    wire [3:0] rx_cnt_n = rx_cnt_q + step;
    wire [3:0] tx_cnt_n = tx_cnt_q + step;

    // Next receive shift value
    reg [7:0] rx_next;
    always @*
    begin
        case (width)
            `W_DUAL: rx_next = {rx_sh_q[5:0], dl_s[1:0]};
            `W_QUAD: rx_next = {rx_sh_q[3:0], dl_s[3:0]};
            default: rx_next = {rx_sh_q[6:0], dl_s[0]};
        endcase
    end

    // Next transmit shift value
    reg [7:0] tx_next;
    always @*
    begin
        if (tx_cnt_n[3])
            tx_next = txd_q;
        else if (width == `W_QUAD)
            tx_next = {tx_sh_q[3:0], 4'h0};
        else if (width == `W_DUAL)
            tx_next = {tx_sh_q[5:0], 2'h0};
        else
            tx_next = {tx_sh_q[6:0], 1'b0};
    end

    // Maps the leading bits of a byte onto the lines
    function [3:0] line_map;
        input [1:0] w;
        input [7:0] b;
        begin
            case (w)
                `W_DUAL: line_map = {2'h0, b[7:6]};
                `W_QUAD: line_map = b[7:4];
                default: line_map = {2'h0, b[7], 1'b0};
            endcase
        end
    endfunction

    // Link side state
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cs_p_q <= 1'b0;
            sclk_p_q <= 1'b0;
            armed_q <= 1'b0;
            paused_q <= 1'b0;
            rx_sh_q <= 8'h00;
            rx_cnt_q <= 4'h0;
            tx_sh_q <= 8'h00;
            tx_cnt_q <= 4'h0;
            skip_q <= 1'b0;
            dl_out_q <= 4'h0;
        end
        else
        begin
            cs_p_q <= cs_s;
            sclk_p_q <= sclk_s;
            if (cs_fall)
                armed_q <= 1'b1;
            // Pause follows the pin only when clock is low
            if (cs_s || !armed_q || quad)
                paused_q <= 1'b0;
            else if (!paused_q && !hold_n && !sclk_s)
                paused_q <= 1'b1;
            else if (paused_q && hold_n && !sclk_s)
                paused_q <= 1'b0;
            if (cs_s)
            begin
                // Partial bytes are dropped on deselect
                rx_cnt_q <= 4'h0;
                tx_cnt_q <= 4'h0;
                rx_sh_q <= 8'h00;
            end
            else if (cs_fall)
            begin
                tx_sh_q <= txd_q;
                dl_out_q <= line_map(width, txd_q);
                // Clock high at select means mode 3: first fall only primes
                skip_q <= sclk_s;
                rx_cnt_q <= 4'h0;
                tx_cnt_q <= 4'h0;
            end
            else
            begin
                if (rx_edge)
                begin
                    rx_sh_q <= rx_next;
                    rx_cnt_q <= rx_cnt_n[3] ? 4'h0 : rx_cnt_n;
                end
                if (tx_edge && skip_q)
                    skip_q <= 1'b0;
                else if (tx_edge)
                begin
                    tx_sh_q <= tx_next;
                    tx_cnt_q <= tx_cnt_n[3] ? 4'h0 : tx_cnt_n;
                    dl_out_q <= line_map(width, tx_next);
                end
            end
        end
    end

    // AHB address phase acceptance
    wire accept = hsel & htrans[1] & hready;
    wire [7:0] acc_addr = haddr[7:0];
    wire rd_rx = accept & ~hwrite & (acc_addr == `OFS_RXD);
    wire rx_done = rx_edge & rx_cnt_n[3] & ~cs_s;
    wire wr_stat = a_wr_q & ((a_addr_q == `OFS_STAT_LO)
                   | (a_addr_q == `OFS_STAT_HI));
    wire wr_state = a_wr_q & (a_addr_q == `OFS_STATE);

    // Register read mux, unmapped offsets read zero
    reg [31:0] rd_mux;
    always @*
    begin
        rd_mux = 32'h0000_0000;
        if (acc_addr == `OFS_STAT_LO)
            rd_mux[7:0] = stat_lo_q;
        else if (acc_addr == `OFS_STAT_HI)
            rd_mux[7:0] = stat_hi_q;
        else if (acc_addr == `OFS_CTRL)
            rd_mux[3:0] = ctrl_q;
        else if (acc_addr == `OFS_TXD)
            rd_mux[7:0] = txd_q;
        else if (acc_addr == `OFS_RXD)
            rd_mux[7:0] = rxd_q;
        else if (acc_addr == `OFS_STATE)
        begin
            rd_mux[`ST_ACT] = active;
            rd_mux[`ST_ARMED] = armed_q;
            rd_mux[`ST_PAUSE] = paused_q;
            rd_mux[`ST_STBY] = standby_q;
            rd_mux[`ST_LOCK] = lock_q;
            rd_mux[`ST_RXV] = rx_valid_q;
            rd_mux[`ST_REJ] = sr_reject_q;
            rd_mux[`ST_ABORT] = abort_q;
            rd_mux[`ST_QREF] = quad_ref_q;
        end
    end

    // Bus side state
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            a_wr_q <= 1'b0;
            a_addr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
            stat_lo_q <= `RST_STAT_LO;
            stat_hi_q <= `RST_STAT_HI;
            ctrl_q <= `RST_CTRL;
            txd_q <= `RST_TXD;
            rxd_q <= 8'h00;
            rx_valid_q <= 1'b0;
            sr_reject_q <= 1'b0;
            abort_q <= 1'b0;
            quad_ref_q <= 1'b0;
        end
        else
        begin
            a_wr_q <= accept & hwrite;
            if (accept)
                a_addr_q <= acc_addr;
            if (accept && !hwrite)
                hrdata_q <= rd_mux;
            // Data phase writes
            if (wr_stat && !hw_lock)
            begin
                if (a_addr_q == `OFS_STAT_LO)
                    stat_lo_q <= hwdata[7:0];
                else
                    stat_hi_q <= hwdata[7:0];
            end
            if (a_wr_q && a_addr_q == `OFS_CTRL)
                ctrl_q <= hwdata[3:0];
            if (a_wr_q && a_addr_q == `OFS_TXD)
                txd_q <= hwdata[7:0];
            // Sticky flags: a new event beats a clear in the same cycle
            if (rx_done)
            begin
                rxd_q <= rx_next;
                rx_valid_q <= 1'b1;
            end
            else if (rd_rx)
                rx_valid_q <= 1'b0;
            if (wr_stat && hw_lock)
                sr_reject_q <= 1'b1;
            else if (wr_state && hwdata[`ST_REJ])
                sr_reject_q <= 1'b0;
            if (cs_rise && paused_q)
                abort_q <= 1'b1;
            else if (wr_state && hwdata[`ST_ABORT])
                abort_q <= 1'b0;
            if (cs_fall && armed_q && w_req == `W_QUAD && !qe)
                quad_ref_q <= 1'b1;
            else if (wr_state && hwdata[`ST_QREF])
                quad_ref_q <= 1'b0;
        end
    end

    // Core-facing status, registered
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            standby_q <= 1'b0;
            lock_q <= 1'b0;
            region_q <= 6'h00;
        end
        else
        begin
            // Busy keeps the part awake; pause never touches it
            standby_q <= cs_s & ~busy;
            lock_q <= hw_lock;
            region_q <= {stat_hi_q[`SH_CMP], stat_lo_q[`SL_SEC],
                         stat_lo_q[`SL_TB],
                         stat_lo_q[`SL_BP_HI:`SL_BP_LO]};
        end
    end

    // Pin drive: only the lines the width needs, only while sending
    wire drive = link_on & dir_out;
    assign data_line_out = dl_out_q;
    assign data_line_oe_n[1] = ~drive;
    assign data_line_oe_n[0] = ~(drive & (width != `W_SINGLE));
    assign data_line_oe_n[3:2] = {2{~(drive & quad)}};

    // Bus answers: zero wait, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    assign standby = standby_q;
    assign status_write_lock = lock_q;
    assign array_protect_lock = lock_q;
    assign protect_region = region_q;

endmodule // flash_pin_front

// ==== sim/flash_pin_front_sva.sv ====
// Checker of the link-side pin behaviour of the flash pin front
module flash_pin_front_sva (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Link pins
    input wire logic chip_select_n,
    input wire logic serial_clock,
    input wire logic [3:0] data_line_in,
    input wire logic [3:0] data_line_out,
    input wire logic [3:0] data_line_oe_n,
    // Status
    input wire logic standby,
    input wire logic status_write_lock,
    input wire logic array_protect_lock
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    logic clk_q;
    logic [3:0] fall_q;
    // Saturates so a long idle spell never wraps back into range
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            clk_q <= 1'b0;
            fall_q <= 4'hF;
        end
        else
        begin
            clk_q <= serial_clock;
            if (clk_q && !serial_clock)
                fall_q <= 4'h0;
            else if (fall_q != 4'hF)
                fall_q <= fall_q + 4'h1;
        end
    end
    property p_float_desel;
        chip_select_n [*5] |-> data_line_oe_n == 4'hF;
    endproperty
    a_float_desel: assert property (p_float_desel)
        else $error("lines driven while deselected");
    property p_active;
        !chip_select_n [*5] |-> !standby;
    endproperty
    a_active: assert property (p_active)
        else $error("standby while selected");
    // Select must have settled low, so the load at select is excluded
    property p_out_after_fall;
        !chip_select_n [*8] ##1 $changed(data_line_out) |-> fall_q <= 4'h6;
    endproperty
    a_out_after_fall: assert property (p_out_after_fall)
        else $error("output moved away from a clock fall");
    property p_dual_pair;
        !data_line_oe_n[0] |-> !data_line_oe_n[1];
    endproperty
    a_dual_pair: assert property (p_dual_pair)
        else $error("line 0 driven without line 1");
    property p_quad_pair;
        !data_line_oe_n[2] |-> data_line_oe_n == 4'h0;
    endproperty
    a_quad_pair: assert property (p_quad_pair)
        else $error("line 2 driven outside a quad transfer");
    property p_pause_float;
        (data_line_oe_n[3] && !data_line_in[3] && !serial_clock
            && !chip_select_n) [*6] |-> data_line_oe_n[1];
    endproperty
    a_pause_float: assert property (p_pause_float)
        else $error("output driven while paused");
    property p_wp_high;
        data_line_in[2] [*5] |-> !status_write_lock;
    endproperty
    a_wp_high: assert property (p_wp_high)
        else $error("lock with protect line high");
    property p_lock_pair;
        status_write_lock == array_protect_lock;
    endproperty
    a_lock_pair: assert property (p_lock_pair)
        else $error("status and array locks differ");
    c_quad: cover property (data_line_oe_n == 4'h0);
    c_pause: cover property (!data_line_oe_n[1] ##1 data_line_oe_n[1]);
    c_lock: cover property ($rose(status_write_lock));
endmodule // flash_pin_front_sva

bind flash_pin_front flash_pin_front_sva u_sva (
    .mclk(mclk), .rst_b(rst_b),
    .chip_select_n(chip_select_n), .serial_clock(serial_clock),
    .data_line_in(data_line_in), .data_line_out(data_line_out),
    .data_line_oe_n(data_line_oe_n), .standby(standby),
    .status_write_lock(status_write_lock),
    .array_protect_lock(array_protect_lock)
);

// ==== sim/spi_host_model.sv ====
// Host controller model: select, serial clock and the four data lines
module spi_host_model (
    // Clock
    input wire logic mclk,
    // Device side of the data lines
    input wire logic [3:0] data_line_out,
    input wire logic [3:0] data_line_oe_n,
    // Link pins
    output logic chip_select_n = 1'b1,
    output logic serial_clock = 1'b0,
    output logic [3:0] data_line_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] hen = 4'hC;
    logic [3:0] hv = 4'hF;
    logic tog = 1'b0;
    always @(posedge mclk)
        tog <= ~tog;
    // Lines 2 and 3 pull up; 0 and 1 wander when nobody drives them
    always @*
        for (int i = 0; i < 4; i++)
            data_line_in[i] = !data_line_oe_n[i] ? data_line_out[i] :
                hen[i] ? hv[i] : (i > 1) ? 1'b1 : tog;
    task automatic pins(input logic [3:0] en, input logic [3:0] v);
        hen <= en;
        hv <= v;
        @(posedge mclk);
    endtask
    task automatic hold_clk(input logic v);
        serial_clock <= v;
        repeat (8) @(posedge mclk);
    endtask
    // Clock idles at the level of the chosen mode before select falls
    task automatic sel(input logic m3);
        hold_clk(m3);
        chip_select_n <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask
    task automatic desel;
        chip_select_n <= 1'b1;
        repeat (8) @(posedge mclk);
    endtask
    task automatic xfer(input logic [1:0] w, input logic [7:0] tx,
                        output logic [7:0] rx);
        int n;
        n = 1 << w;
        rx = 8'h00;
        for (int k = 0; k < 8; k += n)
        begin
            serial_clock <= 1'b0;
            // Only the lines of the width move; the others keep their level
            if (w == 2'h0)
                hv[0] <= tx[7-k];
            else if (w == 2'h1)
                hv[1:0] <= tx[7-k -: 2];
            else
                hv <= tx[7-k -: 4];
            repeat (4) @(posedge mclk);
            serial_clock <= 1'b1;
            rx = (rx << n) | 8'(w == 2'h0 ? data_line_in[1] :
                w == 2'h1 ? data_line_in[1:0] : data_line_in);
            repeat (4) @(posedge mclk);
        end
    endtask
endmodule // spi_host_model

// ==== sim/serial_flash_pin_interface_test.sv ====
// Testbench of the flash pin front: register bus and link scenarios
`include "flash_pins_defs.vh"
module serial_flash_pin_interface_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rv;
    logic [7:0] rx;
    wire hreadyout, hresp, chip_select_n, serial_clock, standby;
    wire status_write_lock, array_protect_lock;
    wire [31:0] hrdata;
    wire [3:0] data_line_in, data_line_out, data_line_oe_n;
    wire [5:0] protect_region;
    int errors = 0;
    int checks_done = 0;
    flash_pin_front u_dut (
        .mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .chip_select_n(chip_select_n),
        .serial_clock(serial_clock), .data_line_in(data_line_in),
        .data_line_out(data_line_out), .data_line_oe_n(data_line_oe_n),
        .standby(standby), .status_write_lock(status_write_lock),
        .array_protect_lock(array_protect_lock),
        .protect_region(protect_region)
    );
    spi_host_model u_host (
        .mclk(mclk), .data_line_out(data_line_out),
        .data_line_oe_n(data_line_oe_n), .chip_select_n(chip_select_n),
        .serial_clock(serial_clock), .data_line_in(data_line_in)
    );
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk(rv, exp);
    endtask
    task automatic t_regs;
        repeat (4) @(posedge mclk);
        chk(standby, 32'h1);
        rdchk(`OFS_STAT_LO, 32'h0);
        rdchk(`OFS_STAT_HI, 32'h0);
        rdchk(`OFS_CTRL, 32'h0);
        rdchk(`OFS_TXD, 32'hFF);
        ahb(1'b1, 8'h20, 32'hFFFFFFFF);
        rdchk(8'h20, 32'h0);
        ahb(1'b1, `OFS_CTRL, 32'h8);
        repeat (6) @(posedge mclk);
        chk(standby, 32'h0);
        ahb(1'b1, `OFS_CTRL, 32'h0);
    endtask
    // Select already low when reset lets go must not arm the device
    task automatic t_power_up;
        u_host.sel(1'b0);
        rst_b <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        u_host.pins(4'hD, 4'hC);
        u_host.xfer(2'h0, 8'hFF, rx);
        ahb(1'b0, `OFS_STATE, 32'h0);
        chk(rv & 32'h22, 32'h0);
        u_host.desel;
    endtask
    task automatic t_rx;
        for (int m = 0; m < 2; m++)
        begin
            u_host.sel(m[0]);
            chk(standby, 32'h0);
            u_host.xfer(2'h0, {7'h2D, m[0]}, rx);
            u_host.desel;
            rdchk(`OFS_RXD, {24'h0, 7'h2D, m[0]});
        end
        // Dual then quad receive; the quad byte drops line 3 low mid-byte
        ahb(1'b1, `OFS_STAT_HI, 32'h2);
        u_host.pins(4'hF, 4'hF);
        for (int w = 1; w < 3; w++)
        begin
            ahb(1'b1, `OFS_CTRL, w);
            u_host.sel(1'b0);
            u_host.xfer(w[1:0], 8'hC6 ^ w[7:0], rx);
            u_host.desel;
            rdchk(`OFS_RXD, 32'hC6 ^ w);
        end
    endtask
    // Last pass asks for quad with the enable bit clear
    task automatic t_tx;
        logic [1:0] lw;
        logic [7:0] pat;
        u_host.pins(4'h0, 4'h0);
        ahb(1'b1, `OFS_STAT_HI, 32'h2);
        for (int w = 0; w < 4; w++)
        begin
            lw = (w == 3) ? 2'h0 : w[1:0];
            pat = 8'hA3 ^ w[7:0];
            if (w == 3)
                ahb(1'b1, `OFS_STAT_HI, 32'h0);
            ahb(1'b1, `OFS_CTRL, {29'h0, 1'b1, (w == 3) ? 2'h2 : lw});
            ahb(1'b1, `OFS_TXD, {24'h0, pat});
            u_host.sel(1'b0);
            u_host.xfer(lw, 8'h00, rx);
            u_host.desel;
            chk(rx, pat);
        end
        ahb(1'b0, `OFS_STATE, 32'h0);
        chk(rv[8], 32'h1);
    endtask
    task automatic t_pause;
        ahb(1'b1, `OFS_CTRL, 32'h4);
        ahb(1'b1, `OFS_TXD, 32'h80);
        u_host.pins(4'hC, 4'hC);
        u_host.sel(1'b1);
        chk(data_line_out[1], 32'h1);
        u_host.pins(4'hC, 4'h4); // Select stays low throughout
        repeat (8) @(posedge mclk);
        chk(data_line_oe_n[1], 32'h0);
        u_host.hold_clk(1'b0);
        chk(data_line_oe_n[1], 32'h1);
        u_host.xfer(2'h0, 8'h00, rx);
        chk(data_line_out[1], 32'h1);
        u_host.pins(4'hC, 4'hC);
        repeat (8) @(posedge mclk);
        chk(data_line_oe_n[1], 32'h1);
        u_host.hold_clk(1'b0);
        chk(data_line_oe_n[1], 32'h0);
        u_host.pins(4'hC, 4'h4);
        repeat (8) @(posedge mclk);
        u_host.desel;
        ahb(1'b0, `OFS_STATE, 32'h0);
        chk(rv[7], 32'h1);
        ahb(1'b1, `OFS_CTRL, 32'h0);
    endtask
    task automatic t_lock;
        ahb(1'b1, `OFS_STAT_LO, 32'h9C);
        u_host.pins(4'hC, 4'h8);
        repeat (6) @(posedge mclk);
        chk(status_write_lock, 32'h1);
        chk(array_protect_lock, 32'h1);
        chk(protect_region, 32'h07);
        ahb(1'b1, `OFS_STAT_LO, 32'h0);
        rdchk(`OFS_STAT_LO, 32'h9C);
        ahb(1'b1, `OFS_STAT_HI, 32'h2);
        rdchk(`OFS_STAT_HI, 32'h0);
        ahb(1'b0, `OFS_STATE, 32'h0);
        chk(rv[6], 32'h1);
        u_host.pins(4'h8, 4'h8);
        repeat (6) @(posedge mclk);
        chk(status_write_lock, 32'h0);
        ahb(1'b1, `OFS_STAT_HI, 32'h2);
        u_host.pins(4'hC, 4'h8);
        repeat (6) @(posedge mclk);
        chk(status_write_lock, 32'h0);
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // The scenarios need well under 10000 clocks; twice that means a hang
    initial
    begin
        #2000000;
        errors++;
        complete_run;
    end
    initial
    begin
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        t_regs;
        t_power_up;
        t_rx;
        t_tx;
        t_pause;
        t_lock;
        complete_run;
    end
endmodule // serial_flash_pin_interface_test
